/* File: src/operand_address_generator.sv */
// Purpose: forms 16-bit operand addresses for the core's memory port
// Assumes: bank registers come from the register file on the same clock
// Notes: one cycle from req to addr_valid; stack addresses outside ram fold to the window base
`timescale 1ns/100ps
module operand_address_generator import oag_pkg::*; #(
    parameter logic [15:0] STACK_LO = HSRAM_LO,
    parameter logic [15:0] STACK_HI = HSRAM_HI
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // bank selection
    input wire logic bank_select_flag_low,
    input wire logic bank_select_flag_high,
    // per-bank pairs, bank n at bits [16n+15:16n]
    input wire logic [BANK_CNT*ADDR_W-1:0] pointer_pair,
    input wire logic [BANK_CNT*ADDR_W-1:0] base_pair,
    input wire logic [BANK_CNT*ADDR_W-1:0] index_pair,
    input wire logic [ADDR_W-1:0] stack_pointer,
    // request from decode
    input wire logic req,
    input wire logic [2:0] mode,
    input wire logic [1:0] stack_src,
    input wire logic [BYTE_W-1:0] imm_byte,
    // memory side
    output logic addr_valid,
    output logic [ADDR_W-1:0] addr,
    output logic addr_is_stack,
    output logic stack_range_err
);
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic valid_r, valid_nxt;
    logic stk_r, stk_nxt;
    logic err_r, err_nxt;
    logic [1:0] bank;
    logic [ADDR_W-1:0] sel_ptr, sel_base, sel_idx;
    logic [ADDR_W-1:0] stk_addr;
    logic stk_out;

    function automatic logic [ADDR_W-1:0] pick(input logic [BANK_CNT*ADDR_W-1:0] v,
                                               input logic [1:0] b);
        pick = v[b*ADDR_W +: ADDR_W];
    endfunction : pick

    assign bank = {bank_select_flag_high, bank_select_flag_low};
    assign sel_ptr = pick(pointer_pair, bank);
    assign sel_base = pick(base_pair, bank);
    assign sel_idx = pick(index_pair, bank);
    assign stk_out = (stack_pointer < STACK_LO) || (stack_pointer > STACK_HI);
    // out-of-window pointer folds to window base rather than hit sfr or flash
    assign stk_addr = stk_out ? STACK_LO : stack_pointer;

    always_comb begin
        addr_nxt = addr_r;
        valid_nxt = 1'b0;
        stk_nxt = stk_r;
        err_nxt = err_r;
        if (req) begin
            valid_nxt = 1'b1;
            stk_nxt = 1'b0;
            err_nxt = 1'b0;
            // stack_src wins so an interrupt save never lands on a data mode
            if (stack_src != STK_NONE || mode == MODE_STACK) begin
                addr_nxt = stk_addr;
                stk_nxt = 1'b1;
                err_nxt = stk_out;
            end else begin
                case (mode)
                    MODE_PTR_IND: addr_nxt = sel_ptr;
                    MODE_BASE_IND: addr_nxt = sel_base;
                    // zero extension, carry out of bit 15 dropped
                    MODE_BASED: addr_nxt = ADDR_W'(sel_base + {8'h00, imm_byte});
                    MODE_IDX_LOW: addr_nxt = ADDR_W'(sel_base + {8'h00, sel_idx[7:0]});
                    MODE_IDX_HIGH: addr_nxt = ADDR_W'(sel_base + {8'h00, sel_idx[15:8]});
                    // spare codes fall back to the base pair, harmless on the bus
                    default: addr_nxt = sel_base;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= ADDR_RST;
            valid_r <= 1'b0;
            stk_r <= 1'b0;
            err_r <= 1'b0;
        end else if (clk_en) begin
            addr_r <= addr_nxt;
            valid_r <= valid_nxt;
            stk_r <= stk_nxt;
            err_r <= err_nxt;
        end
    end

    assign addr = addr_r;
    assign addr_valid = valid_r;
    assign addr_is_stack = stk_r;
    assign stack_range_err = err_r;

    // assertions
    // register indirect, bank choice and spare codes
    ptr_indirect_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_PTR_IND
        |=> addr == $past(sel_ptr) && addr_valid)
        else $error("pointer indirect wrong");

    bank_pick_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_BASE_IND
        |=> addr == $past(base_pair[bank*ADDR_W +: ADDR_W]))
        else $error("bank select wrong");

    spare_mode_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode > 3'h5
        |=> addr == $past(sel_base) && !addr_is_stack)
        else $error("spare mode not base pair");

    // based and based-indexed sums, base indirect width
    based_wrap_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_BASED
        |=> addr == ADDR_W'($past(sel_base) + $past({8'h00, imm_byte})))
        else $error("based address wrong");

    disp_unsigned_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_BASED && imm_byte[7]
        && sel_base < 16'hff00 |=> addr > $past(sel_base))
        else $error("displacement sign extended");

    idx_low_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_IDX_LOW
        |=> ADDR_W'(addr - $past(sel_base)) == {8'h00, $past(sel_idx[7:0])})
        else $error("low indexed address wrong");

    idx_high_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_IDX_HIGH
        |=> ADDR_W'(addr - $past(sel_base)) == {8'h00, $past(sel_idx[15:8])})
        else $error("indexed address wrong");

    full_width_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode == MODE_BASE_IND
        && sel_base[15:12] == 4'hf |=> addr[15:12] == 4'hf)
        else $error("address truncated");

    // stack path
    stack_sp_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && mode == MODE_STACK && !stk_out
        |=> addr == $past(stack_pointer) && addr_is_stack)
        else $error("stack address wrong");

    stack_src_sp_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src != STK_NONE
        && stack_pointer >= STACK_LO && stack_pointer <= STACK_HI
        |=> addr == $past(stack_pointer) && !stack_range_err)
        else $error("forced stack address wrong");

    stack_force_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src != STK_NONE |=> addr_is_stack)
        else $error("stack not forced");

    stack_clamp_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && (stack_src != STK_NONE || mode == MODE_STACK)
        && (stack_pointer < STACK_LO || stack_pointer > STACK_HI)
        |=> addr == STACK_LO && stack_range_err)
        else $error("stack pointer not clamped");

    stack_window_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        addr_is_stack |-> addr >= STACK_LO && addr <= STACK_HI)
        else $error("stack outside ram");

    err_stack_only_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        stack_range_err |-> addr_is_stack)
        else $error("range error without stack access");

    non_stack_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && req && stack_src == STK_NONE && mode != MODE_STACK
        |=> !addr_is_stack && !stack_range_err)
        else $error("stale stack flags");

    // answer timing and clock enable
    valid_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en |=> addr_valid == $past(req))
        else $error("valid not one cycle after request");

    idle_hold_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && !req
        |=> !addr_valid && $stable(addr) && $stable(addr_is_stack) && $stable(stack_range_err))
        else $error("outputs moved without request");

    freeze_hold_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !clk_en |=> $stable(addr) && $stable(addr_valid) && $stable(addr_is_stack)
        && $stable(stack_range_err))
        else $error("state moved while frozen");
endmodule : operand_address_generator

/* File: pkg/oag_pkg.sv */
// Purpose: constants for the operand address generator
// Assumes: 8-bit core with four banks of eight byte registers
// Notes: stack window limits are parameters of the top module
package oag_pkg;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int BANK_CNT = 4;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    // stack window: internal high-speed ram
    localparam logic [15:0] HSRAM_LO = 16'hfb00;
    localparam logic [15:0] HSRAM_HI = 16'hfeff;

    typedef enum logic [2:0] {
        MODE_PTR_IND = 3'b000,
        MODE_BASE_IND = 3'b001,
        MODE_BASED = 3'b010,
        MODE_IDX_LOW = 3'b011,
        MODE_IDX_HIGH = 3'b100,
        MODE_STACK = 3'b101
    } addr_mode_e;

    typedef enum logic [1:0] {
        STK_NONE = 2'b00,
        STK_PUSHPOP = 2'b01,
        STK_CALLRET = 2'b10,
        STK_INTSAVE = 2'b11
    } stack_src_e;
endpackage : oag_pkg

/* File: tb/ram_side_model.sv */
// Purpose: memory side stand-in, flags stack accesses landing outside ram
// Assumes: stack window is the package default
// Notes: sticky flag, read by the bench at the end of the stack test
`timescale 1ns/100ps
module ram_side_model import oag_pkg::*; (
    // memory port
    input wire logic ref_clk,
    input wire logic addr_valid,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic addr_is_stack,
    // status
    output logic stray
);
    initial stray = 1'b0;
    always @(posedge ref_clk) begin
        if (addr_valid && addr_is_stack && (addr < HSRAM_LO || addr > HSRAM_HI)) begin
            stray <= 1'b1;
        end
    end
endmodule : ram_side_model

/* File: tb/operand_address_generator_tb_top.sv */
// Purpose: directed bench for the operand address generator
// Assumes: one-cycle answer, inputs driven on falling edges
// Notes: bank n pointer and base pairs are distinct so a wrong bank shows at once
`timescale 1ns/100ps
module operand_address_generator_tb_top import oag_pkg::*;;
    logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, req = 1'b0, stray;
    logic bank_select_flag_low = 1'b0, bank_select_flag_high = 1'b0;
    logic [63:0] pointer_pair = 64'h4444_3333_2222_1111;
    logic [63:0] base_pair = 64'hfff0_8000_ff80_0100;
    logic [63:0] index_pair = 64'h2030_0000_0000_0000;
    logic [15:0] stack_pointer = 16'hfe80;
    logic [2:0] mode = 3'h0;
    logic [1:0] stack_src = 2'h0;
    logic [7:0] imm_byte = 8'h00;
    logic addr_valid, addr_is_stack, stack_range_err;
    logic [15:0] addr;
    int num_errors = 0;
    int checks_done = 0;
    operand_address_generator dut (.ref_clk, .arst_n, .clk_en, .bank_select_flag_low,
        .bank_select_flag_high, .pointer_pair, .base_pair, .index_pair, .stack_pointer,
        .req, .mode, .stack_src, .imm_byte, .addr_valid, .addr, .addr_is_stack,
        .stack_range_err);
    ram_side_model ram (.ref_clk, .addr_valid, .addr, .addr_is_stack, .stray);
    always #4 ref_clk = ~ref_clk;
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one request, answer seen one edge later
    task automatic issue(input logic [4:0] ms, input logic [7:0] b, input logic [18:0] e);
        {mode, stack_src} = ms;
        imm_byte = b;
        req = 1'b1;
        @(negedge ref_clk);
        chk({stack_range_err, addr_is_stack, addr_valid, addr}, e);
        req = 1'b0;
        // valid is a one-cycle pulse, the address itself must hold
        @(negedge ref_clk);
        chk({stack_range_err, addr_is_stack, addr_valid, addr}, e & 19'h6_ffff);
    endtask : issue
    task automatic t_indirect();
        {bank_select_flag_high, bank_select_flag_low} = 2'h2;
        issue(5'h00, 8'h00, 19'h1_3333);
        issue(5'h04, 8'h00, 19'h1_8000);
        issue(5'h1c, 8'h00, 19'h1_8000);
    endtask : t_indirect
    task automatic t_based();
        {bank_select_flag_high, bank_select_flag_low} = 2'h1;
        issue(5'h08, 8'hff, 19'h1_007f);
        {bank_select_flag_high, bank_select_flag_low} = 2'h0;
        issue(5'h08, 8'h80, 19'h1_0180);
    endtask : t_based
    task automatic t_indexed();
        {bank_select_flag_high, bank_select_flag_low} = 2'h3;
        issue(5'h0c, 8'h00, 19'h1_0020);
        issue(5'h10, 8'h00, 19'h1_0010);
        issue(5'h04, 8'h00, 19'h1_fff0);
    endtask : t_indexed
    task automatic t_stack();
        for (int s = 1; s < 4; s++) issue(5'(s), 8'h00, 19'h3_fe80);
        issue(5'h14, 8'h00, 19'h3_fe80);
        stack_pointer = 16'h0100;
        issue(5'h14, 8'h00, 19'h7_fb00);
        chk({18'h0, stray}, 19'h0);
    endtask : t_stack
    // a frozen cycle must neither take a request nor drop the pending answer
    task automatic t_freeze();
        {bank_select_flag_high, bank_select_flag_low} = 2'h0;
        {mode, stack_src} = 5'h00;
        req = 1'b1;
        @(negedge ref_clk);
        clk_en = 1'b0;
        {mode, stack_src} = 5'h04;
        @(negedge ref_clk);
        chk({stack_range_err, addr_is_stack, addr_valid, addr}, 19'h1_1111);
        req = 1'b0;
        clk_en = 1'b1;
        @(negedge ref_clk);
        chk({stack_range_err, addr_is_stack, addr_valid, addr}, 19'h0_1111);
    endtask : t_freeze
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        t_indirect();
        t_based();
        t_indexed();
        t_stack();
        t_freeze();
        end_sim();
    end
    initial begin
        #2000;
        num_errors++;
        end_sim();
    end
endmodule : operand_address_generator_tb_top
